// ==== design/cssc_ctl.sv ====
// Purpose: charge state, fault hold-off and supervisor hand-off control
// Assumes: packet decoding done upstream, same clock
// Notes: one packed state struct
`timescale 1ns/1ps
`include "cssc_params.svh"
`default_nettype none
module cssc_ctl
  import cssc_pkg::*;
#(
  parameter int TICK_CYC = `CSSC_TICK_CYC,
  parameter int CC_HOLD_TICKS = `CSSC_CC_HOLD_TICKS,
  parameter int OC_HOLD_TICKS = `CSSC_OC_HOLD_TICKS,
  parameter int WAKE_TICKS = `CSSC_WAKE_TICKS,
  parameter int BOOT_WORDS = 16
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ept_valid,
  input wire logic [7:0] i_ept_code,
  input wire logic i_cs_valid,
  input wire logic [7:0] i_cs_percent,
  input wire logic i_rx_present,
  input wire logic i_overcurrent,
  input wire logic i_supervisor_strap,
  input wire logic i_boot_ready,
  output logic o_power_en,
  output logic [1:0] o_led,
  output logic o_fault,
  output logic o_boot_valid,
  output logic [7:0] o_boot_data,
  output logic o_standby_cmd,
  output logic o_ping
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    cssc_state_t fsm;
    cssc_led_t led;
    logic sup_fitted;
    logic [2:0] strap_cnt;
    logic [7:0] boot_idx;
    logic [31:0] div;
    logic [31:0] hold;
    logic [31:0] wake;
    logic power_en;
    logic fault;
    logic boot_valid;
    logic [7:0] boot_data;
    logic standby_cmd;
    logic ping;
  } cssc_ctl_t;
  cssc_ctl_t st_reg;
  cssc_ctl_t st_next;
  logic oc_level;
  logic strap_level;
  logic tick;
  logic [7:0] fw_rom [BOOT_WORDS];
  // ************************************************
  // embedded supervisor image
  // ************************************************
  genvar gi;
  generate
    for (gi = 0; gi < BOOT_WORDS; gi++)
    begin : g_rom
      assign fw_rom[gi] = 8'(gi * 37 + 5);
    end
  endgenerate
  cssc_sync u_oc_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_overcurrent),
    .o_level(oc_level)
  );
  cssc_sync u_strap_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_pin(i_supervisor_strap),
    .o_level(strap_level)
  );
  assign tick = (st_reg.div == 32'(TICK_CYC - 1));
  // ************************************************
  // next state
  // ************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.ping = 1'b0;
    st_next.standby_cmd = 1'b0;
    st_next.div = tick ? 32'h0 : st_reg.div + 32'h1;
    if (tick && st_reg.hold != 32'h0)
    begin
      st_next.hold = st_reg.hold - 32'h1;
    end
    if (i_cs_valid && st_reg.led == CSSC_LED_DONE && i_cs_percent < `CSSC_CS_LOW)
    begin
      st_next.led = CSSC_LED_CHARGING;
    end
    case (st_reg.fsm)
      CSSC_ST_STRAP:
      begin
        st_next.strap_cnt = st_reg.strap_cnt + 3'h1;
        if (st_reg.strap_cnt == `CSSC_STRAP_CNT)
        begin
          st_next.sup_fitted = strap_level;
          st_next.fsm = strap_level ? CSSC_ST_BOOT : CSSC_ST_IDLE;
        end
      end
      CSSC_ST_BOOT:
      begin
        st_next.boot_valid = 1'b1;
        st_next.boot_data = fw_rom[st_reg.boot_idx[3:0]];
        if (st_reg.boot_valid && i_boot_ready)
        begin
          if (st_reg.boot_idx == 8'(BOOT_WORDS - 1))
          begin
            st_next.boot_valid = 1'b0;
            st_next.fsm = CSSC_ST_IDLE;
          end
          else
          begin
            st_next.boot_idx = st_reg.boot_idx + 8'h1;
            st_next.boot_data = fw_rom[st_reg.boot_idx[3:0] + 4'h1];
          end
        end
      end
      CSSC_ST_IDLE:
      begin
        st_next.fault = 1'b0;
        if (i_rx_present)
        begin
          st_next.power_en = 1'b1;
          if (st_reg.led != CSSC_LED_DONE)
          begin
            st_next.led = CSSC_LED_CHARGING;
          end
          st_next.fsm = CSSC_ST_POWER;
        end
        else
        begin
          st_next.wake = 32'(WAKE_TICKS);
          st_next.fsm = CSSC_ST_STANDBY;
        end
      end
      CSSC_ST_POWER:
      begin
        if (oc_level)
        begin
          st_next.power_en = 1'b0;
          st_next.fault = 1'b1;
          st_next.led = CSSC_LED_FAULT;
          st_next.hold = 32'(OC_HOLD_TICKS);
          st_next.fsm = CSSC_ST_HOLD;
        end
        else if (i_ept_valid && i_ept_code == `CSSC_EPT_CHARGE_DONE)
        begin
          st_next.power_en = 1'b0;
          st_next.led = CSSC_LED_DONE;
          st_next.hold = 32'(CC_HOLD_TICKS);
          st_next.fsm = CSSC_ST_HOLD;
        end
        else if (i_cs_valid && i_cs_percent == `CSSC_CS_FULL)
        begin
          st_next.led = CSSC_LED_DONE;
        end
        else if (!i_rx_present)
        begin
          st_next.power_en = 1'b0;
          st_next.fsm = CSSC_ST_IDLE;
        end
      end
      CSSC_ST_HOLD:
      begin
        if (st_reg.hold == 32'h0)
        begin
          st_next.fsm = CSSC_ST_IDLE;
        end
      end
      CSSC_ST_STANDBY:
      begin
        if (i_rx_present)
        begin
          st_next.fsm = CSSC_ST_IDLE;
        end
        else if (tick)
        begin
          if (st_reg.wake == 32'h0)
          begin
            st_next.ping = 1'b1;
            st_next.wake = 32'(WAKE_TICKS);
            st_next.standby_cmd = st_reg.sup_fitted;
          end
          else
          begin
            st_next.wake = st_reg.wake - 32'h1;
          end
        end
      end
      default:
      begin
        st_next.fsm = CSSC_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign o_power_en = st_reg.power_en;
  assign o_led = st_reg.led;
  assign o_fault = st_reg.fault;
  assign o_boot_valid = st_reg.boot_valid;
  assign o_boot_data = st_reg.boot_data;
  assign o_standby_cmd = st_reg.standby_cmd;
  assign o_ping = st_reg.ping;
endmodule
`default_nettype wire

// ==== inc/cssc_params.svh ====
// Purpose: constants for the charge state supervisor controller
// Assumes: 200 MHz clock, tick-based hold-off timing
// Notes: counts derived from times and clock rate
// Contract
// - end-of-power charge complete: green, halt 5 s
// - full charge status: complete LED, keep power
// - status below 90 percent restores charging LED
// - overcurrent: fault, halt one minute, retry
// - strap fitted: boot-load supervisor at first power-up
// - standby with supervisor: issue standby entry command
// - standby wake every 400 ms to ping (code pings every 401 ms)
`ifndef CSSC_PARAMS_SVH
`define CSSC_PARAMS_SVH
`define CSSC_CLK_MHZ 200
`define CSSC_TICK_US 1000
`define CSSC_TICK_CYC (`CSSC_TICK_US * `CSSC_CLK_MHZ)
`define CSSC_CC_HOLD_S 5
`define CSSC_OC_HOLD_S 60
`define CSSC_CC_HOLD_TICKS (`CSSC_CC_HOLD_S * 1000000 / `CSSC_TICK_US)
`define CSSC_OC_HOLD_TICKS (`CSSC_OC_HOLD_S * 1000000 / `CSSC_TICK_US)
`define CSSC_WAKE_MS 400
`define CSSC_WAKE_TICKS (`CSSC_WAKE_MS * 1000 / `CSSC_TICK_US)
`define CSSC_EPT_CHARGE_DONE 8'h01
`define CSSC_CS_FULL 8'h64
`define CSSC_CS_LOW 8'h5a
`define CSSC_STRAP_CNT 3'h7
`endif

// ==== inc/cssc_pkg.sv ====
// Purpose: types for the charge state supervisor controller
// Assumes: nothing
// Notes: led and controller states
package cssc_pkg;
  typedef enum logic [1:0] {CSSC_LED_OFF, CSSC_LED_CHARGING, CSSC_LED_DONE, CSSC_LED_FAULT} cssc_led_t;
  typedef enum logic [2:0] {CSSC_ST_STRAP, CSSC_ST_BOOT, CSSC_ST_IDLE, CSSC_ST_POWER, CSSC_ST_HOLD,
                            CSSC_ST_STANDBY} cssc_state_t;
endpackage

// ==== design/cssc_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: asynchronous pin input
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cssc_sync
  import cssc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } cssc_sync_t;
  cssc_sync_t st_reg;
  cssc_sync_t st_next;
  always_comb
  begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[1:0], i_pin};
    if (st_reg.stage[1] == st_reg.stage[2])
    begin
      st_next.level = st_reg.stage[2];
    end
  end
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign o_level = st_reg.level;
endmodule
`default_nettype wire

// ==== bench/cssc_partner.sv ====
// Purpose: slow supervisor model taking boot bytes
// Assumes: ready toggles, so every byte after the first meets a stall
// Notes: counts accepted bytes
`timescale 1ns/1ps
`default_nettype none
module cssc_partner
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire logic [1:0] i_led,
  output logic o_ready,
  output int o_count,
  output logic [1:0] o_led_kept
);
  // ready every other cycle, changed just after the edge
  always @(posedge i_mclk)
  begin
    o_ready <= #1 i_rstn && !o_ready;
    if (!i_rstn)
      o_count <= 0;
    else if (i_valid && o_ready)
      o_count <= o_count + 1;
    if (i_rstn)
      o_led_kept <= i_led;
  end
endmodule
`default_nettype wire

// ==== bench/cssc_ctl_monitor.sv ====
// Purpose: port checker for cssc_ctl
// Assumes: short hold-offs in simulation
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module cssc_ctl_monitor
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ept_valid,
  input wire logic [7:0] i_ept_code,
  input wire logic i_cs_valid,
  input wire logic [7:0] i_cs_percent,
  input wire logic i_rx_present,
  input wire logic i_overcurrent,
  input wire logic i_supervisor_strap,
  input wire logic i_boot_ready,
  input wire logic o_power_en,
  input wire logic [1:0] o_led,
  input wire logic o_fault,
  input wire logic o_boot_valid,
  input wire logic [7:0] o_boot_data,
  input wire logic o_standby_cmd,
  input wire logic o_ping
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  property p_ept;
    o_power_en && !o_fault && i_ept_valid && i_ept_code == 8'h01 |=> !o_power_en && o_led == 2'h2;
  endproperty
  a_ept: assert property (p_ept) else $error("charge done stop wrong");
  property p_full;
    o_power_en && !o_fault && !i_ept_valid && i_cs_valid && i_cs_percent == 8'h64 |=> o_power_en && o_led == 2'h2;
  endproperty
  a_full: assert property (p_full) else $error("full status wrong");
  property p_low;
    o_power_en && o_led == 2'h2 && i_cs_valid && i_cs_percent < 8'h5a |=> o_led == 2'h1;
  endproperty
  a_low: assert property (p_low) else $error("charging led not restored");
  property p_oc;
    $rose(o_fault) |-> !o_power_en && $past(i_overcurrent, 4) && $past(i_overcurrent, 5);
  endproperty
  a_oc: assert property (p_oc) else $error("fault without cause");
  property p_hold;
    $fell(o_power_en) |-> !o_power_en [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("hold-off too short");
  property p_boot;
    o_boot_valid && !i_boot_ready |=> o_boot_valid && $stable(o_boot_data);
  endproperty
  a_boot: assert property (p_boot) else $error("boot byte dropped");
  property p_sby;
    o_standby_cmd |-> o_ping && i_supervisor_strap;
  endproperty
  a_sby: assert property (p_sby) else $error("standby command misplaced");
  property p_ping;
    o_ping |=> !o_ping [*8];
  endproperty
  a_ping: assert property (p_ping) else $error("ping too frequent");
  c_ping: cover property (o_ping);
  c_boot: cover property (o_boot_valid && i_boot_ready);
  c_fault: cover property ($rose(o_fault));
endmodule
bind cssc_ctl cssc_ctl_monitor i_mon(.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ept_valid(i_ept_valid),
  .i_ept_code(i_ept_code), .i_cs_valid(i_cs_valid), .i_cs_percent(i_cs_percent), .i_rx_present(i_rx_present),
  .i_overcurrent(i_overcurrent), .i_supervisor_strap(i_supervisor_strap), .i_boot_ready(i_boot_ready),
  .o_power_en(o_power_en), .o_led(o_led), .o_fault(o_fault), .o_boot_valid(o_boot_valid),
  .o_boot_data(o_boot_data), .o_standby_cmd(o_standby_cmd), .o_ping(o_ping));
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: directed bench for cssc_ctl
// Assumes: tick 4 cycles, short hold-offs
// Notes: inputs driven 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = 4;
  logic clk = 0, rstn = 0, ev = 0, cv = 0, rx = 0, oc = 0, strap = 1, rdy, pen, flt, bv, sby, png;
  logic [7:0] ec = 0, cp = 0, bd;
  logic [1:0] led, kled;
  int failures = 0, n_compared = 0, nb, n;
  always #2.5 clk = ~clk;
  cssc_ctl #(.TICK_CYC(TK), .CC_HOLD_TICKS(5), .OC_HOLD_TICKS(8), .WAKE_TICKS(3)) i_cssc_ctl(.i_mclk(clk),
    .i_rstn(rstn), .i_ept_valid(ev), .i_ept_code(ec), .i_cs_valid(cv), .i_cs_percent(cp), .i_rx_present(rx),
    .i_overcurrent(oc), .i_supervisor_strap(strap), .i_boot_ready(rdy), .o_power_en(pen), .o_led(led),
    .o_fault(flt), .o_boot_valid(bv), .o_boot_data(bd), .o_standby_cmd(sby), .o_ping(png));
  cssc_partner i_cssc_partner(.i_mclk(clk), .i_rstn(rstn), .i_valid(bv), .i_led(led), .o_ready(rdy),
    .o_count(nb), .o_led_kept(kled));
  // ******************************
  // helpers
  // ******************************
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc;
    @(posedge clk);
    #1;
  endtask
  // cycles until pen reaches v, bounded
  task wait_pen(input logic v);
    n = 0;
    while (pen !== v && n < 300)
    begin
      cyc;
      n++;
    end
  endtask
  task pkt(input logic e, input logic [7:0] v);
    ev = e;
    cv = !e;
    ec = v;
    cp = v;
    cyc;
    ev = 0;
    cv = 0;
    cyc;
  endtask
  // ******************************
  // scenarios
  // ******************************
  task t_boot_standby;
    n = 0;
    while ((nb < 16 || !png) && n < 600)
    begin
      cyc;
      n++;
    end
    chk("boot bytes", nb, 16);
    chk("standby cmd", sby, 1);
    cyc;
    n = 1;
    while (!png && n < 300)
    begin
      cyc;
      n++;
    end
    chk("ping period", n, 4 * TK);
    $display("boot and standby done");
  endtask
  task t_ept;
    rx = 1;
    wait_pen(1);
    chk("charging led", led, 1);
    pkt(1, 8'h01);
    chk("ept power", pen, 0);
    chk("ept led", led, 2);
    wait_pen(1);
    chk("ept hold", n >= 4 * TK && n <= 5 * TK, 1);
    $display("end of power done");
  endtask
  task t_cs;
    pkt(0, 8'h59);
    chk("low led", led, 1);
    pkt(0, 8'h64);
    chk("full power", pen, 1);
    chk("full led", led, 2);
    pkt(0, 8'h5a);
    chk("90 led", led, 2);
    pkt(0, 8'h59);
    chk("89 led", led, 1);
    $display("charge status done");
  endtask
  task t_oc;
    oc = 1;
    n = 0;
    while (!flt && n < 10)
    begin
      cyc;
      n++;
    end
    chk("oc delay", n >= 4 && n <= 5, 1);
    chk("oc power", pen, 0);
    chk("oc led", led, 3);
    oc = 0;
    wait_pen(1);
    chk("oc hold", n >= 7 * TK && n <= 8 * TK + 2, 1);
    chk("oc clear", flt, 0);
    $display("overcurrent done");
  endtask
  task t_sleep;
    rx = 0;
    n = 0;
    while (!png && n < 100)
    begin
      cyc;
      n++;
    end
    chk("sleep ping", png, 1);
    chk("sleep cmd", sby, 1);
    rstn = 0;
    strap = 0;
    cyc;
    chk("reset power", pen, 0);
    chk("reset led", led, 0);
    chk("kept led", kled, 1);
    cyc;
    rstn = 1;
    n = 0;
    while (!png && n < 100)
    begin
      cyc;
      n++;
    end
    chk("bare ping", png, 1);
    chk("bare cmd", sby, 0);
    chk("bare boot", nb, 0);
    $display("standby reset done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    t_boot_standby;
    t_ept;
    t_cs;
    t_oc;
    t_sleep;
    give_verdict;
  end
  initial
  begin
    #20000;
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
